// ### core/epwrs_defs.vh
// Constants shared by the serial EEPROM slave front end
`ifndef EPWRS_DEFS_VH
`define EPWRS_DEFS_VH

// Control byte layout and device-type code (code value is arbitrary)
`define EPWRS_DEV_CODE      4'h6 // Arbitrary device-type code value
`define EPWRS_CODE_MSB      7
`define EPWRS_CODE_LSB      4
`define EPWRS_CHIP_MSB      3
`define EPWRS_CHIP_LSB      1
`define EPWRS_RW_BIT        0

// Page buffer and array geometry
`define EPWRS_PAGE_BYTES    2
`define EPWRS_ADDR_W        8
`define EPWRS_DATA_W        8
`define EPWRS_ARRAY_WORDS   256

// Bit counter marks inside one nine-clock frame
`define EPWRS_BIT_LAST      4'h8
`define EPWRS_BIT_MACK      4'h9

// Program time per byte and clock rate
`define EPWRS_PROG_MS       1
`define EPWRS_CLK_KHZ       50000
// One program slot in reference clock cycles, sized for the 16-bit timer
`define EPWRS_PROG_CYC      16'hC350

// Reset values
`define EPWRS_PTR_RST       8'h00

`endif

// ### core/epwrs_fifo.v
// Two-entry valid/ready buffer holding page-write bytes with their addresses
`default_nettype none

module epwrs_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire             ref_clk_i,
  input  wire             srst_i,
  input  wire             clk_en_i,
  input  wire             flush_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  // Flush drops everything; used when a write is aborted
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else if (clk_en_i) begin
      if (flush_i) begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q  <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          mem_q[wr_ptr_q] <= in_data_i;
          wr_ptr_q        <= wr_ptr_q + 1'b1;
        end
        if (pop) begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
        end
        if (push & ~pop) begin
          count_q <= count_q + 1'b1;
        end else if (pop & ~push) begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

endmodule // epwrs_fifo

`default_nettype wire

// ### core/epwrs_slave.v
// Two-wire serial EEPROM slave: page write, program timer and reads
`include "epwrs_defs.vh"
`default_nettype none

module epwrs_slave #(
  parameter [15:0] PROG_CYCLES = `EPWRS_PROG_CYC
) (
  input  wire       ref_clk_i,
  input  wire       srst_i,
  input  wire       clk_en_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire       chip_strap_bit0,
  input  wire       chip_strap_bit1,
  input  wire       chip_strap_bit2,
  output wire       prog_busy_o,
  output reg        wr_strobe_o,
  output reg  [7:0] wr_addr_o,
  output reg  [7:0] wr_data_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CTRL = 3'h1;
  localparam [2:0] ST_WADR = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;

  reg [7:0]  array_q [0:`EPWRS_ARRAY_WORDS-1];
  reg [2:0]  state_q;
  reg [3:0]  cnt_q;
  reg [7:0]  sr_q;
  reg [7:0]  tx_q;
  reg [7:0]  ptr_q;
  reg        scl_q;
  reg        sda_q;
  reg        ack_q;
  reg        rw_q;
  reg        mack_q;
  reg        prog_run_q;
  reg [15:0] tmr_q;
  reg        push;
  reg        flush;
  wire       start;
  wire       stop;
  wire       rise;
  wire       fall;
  wire       match;
  wire       fifo_ready;
  wire       fifo_valid;
  wire       fifo_pop;
  wire [15:0] fifo_data;
  wire [7:0] rd_byte;
  wire       prog_go;

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  // SCL is sampled like data; the block never drives it
  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  // SDA edges while SCL stays high are conditions, never data
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;

  // Address compare with the straps, blocked while programming
  assign match = (sr_q[`EPWRS_CODE_MSB:`EPWRS_CODE_LSB] == `EPWRS_DEV_CODE) &
                 (sr_q[`EPWRS_CHIP_MSB:`EPWRS_CHIP_LSB] ==
                  {chip_strap_bit2, chip_strap_bit1, chip_strap_bit0}) &
                 ~prog_run_q;

  assign rd_byte     = array_q[ptr_q];
  assign prog_busy_o = prog_run_q;
  // Programming only follows a STOP that closes a write with bytes held
  assign prog_go     = stop & (state_q == ST_WDAT) & fifo_valid & ~prog_run_q;

  // ----------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------
  // SDA is only pulled low on SCL falling edges; START and STOP just
  // release it, so data never moves under a high clock
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'h0;
      sr_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= `EPWRS_PTR_RST;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (start) begin
        state_q  <= ST_CTRL;
        cnt_q    <= 4'h0;
        ack_q    <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop) begin
        state_q  <= ST_IDLE;
        cnt_q    <= 4'h0;
        ack_q    <= 1'b0;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_q)
          ST_CTRL, ST_WADR, ST_WDAT: begin
            if (rise && cnt_q != `EPWRS_BIT_LAST) begin
              sr_q  <= {sr_q[6:0], sda_i};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && ack_q) begin
              // End of the ninth clock: release and move on
              ack_q    <= 1'b0;
              cnt_q    <= 4'h0;
              sda_oe_o <= 1'b0;
              if (state_q == ST_CTRL && rw_q) begin
                state_q  <= ST_RD;
                tx_q     <= rd_byte;
                sda_oe_o <= ~rd_byte[7];
                ptr_q    <= ptr_q + 8'h01;
              end else if (state_q == ST_CTRL) begin
                state_q <= ST_WADR;
              end else begin
                state_q <= ST_WDAT;
              end
            end else if (fall && cnt_q == `EPWRS_BIT_LAST) begin
              if (state_q == ST_CTRL && !match) begin
                state_q <= ST_IDLE;
              end else if (state_q == ST_WDAT && !fifo_ready) begin
                state_q <= ST_IDLE;
              end else begin
                // Pull SDA low for the ninth clock
                ack_q    <= 1'b1;
                sda_oe_o <= 1'b1;
                if (state_q == ST_CTRL) begin
                  rw_q <= sr_q[`EPWRS_RW_BIT];
                end
                if (state_q == ST_WADR) begin
                  ptr_q <= sr_q;
                end
                if (state_q == ST_WDAT) begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          ST_RD: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `EPWRS_BIT_LAST) begin
                mack_q <= ~sda_i;
              end
            end else if (fall) begin
              if (cnt_q < `EPWRS_BIT_LAST) begin
                tx_q     <= {tx_q[6:0], 1'b0};
                sda_oe_o <= ~tx_q[6];
              end else if (cnt_q == `EPWRS_BIT_LAST) begin
                sda_oe_o <= 1'b0; // Master owns the ack clock
              end else if (mack_q) begin
                cnt_q    <= 4'h0;
                tx_q     <= rd_byte;
                sda_oe_o <= ~rd_byte[7];
                ptr_q    <= ptr_q + 8'h01;
              end else begin
                state_q  <= ST_IDLE;
                sda_oe_o <= 1'b0;
              end
            end
          end
          default: begin
            state_q  <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Page buffer control
  // ----------------------------------------------------------------
  // A byte is queued when it is acked; a third byte finds the buffer
  // full and the whole write is dropped before anything is programmed.
  // A START that cuts a write short also discards its bytes, but never
  // while programming, when the buffer is being drained.
  always @* begin
    push  = 1'b0;
    flush = 1'b0;
    if (!start && !stop && state_q == ST_WDAT && fall && !ack_q &&
        cnt_q == `EPWRS_BIT_LAST) begin
      push  = fifo_ready;
      flush = ~fifo_ready;
    end
    if (start && !prog_run_q && fifo_valid) begin
      flush = 1'b1;
    end
  end

  epwrs_fifo #(
    .WIDTH (16),
    .DEPTH (`EPWRS_PAGE_BYTES),
    .AW    (1)
  ) u_page_buf (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .clk_en_i    (clk_en_i),
    .flush_i     (flush),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({ptr_q, sr_q}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Self-timed program cycle
  // ----------------------------------------------------------------
  // One byte is taken per time slot, so N bytes take N slots; the
  // buffer stalls until the running slot has expired
  assign fifo_pop = prog_run_q & (tmr_q == 16'h0000) & fifo_valid;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      prog_run_q  <= 1'b0;
      tmr_q       <= 16'h0000;
      wr_strobe_o <= 1'b0;
      wr_addr_o   <= 8'h00;
      wr_data_o   <= 8'h00;
    end else if (clk_en_i) begin
      wr_strobe_o <= 1'b0;
      if (prog_go) begin
        prog_run_q <= 1'b1;
        tmr_q      <= 16'h0000;
      end else if (prog_run_q) begin
        if (tmr_q != 16'h0000) begin
          tmr_q <= tmr_q - 16'h0001;
        end else if (fifo_valid) begin
          array_q[fifo_data[15:8]] <= fifo_data[7:0];
          wr_strobe_o <= 1'b1;
          wr_addr_o   <= fifo_data[15:8];
          wr_data_o   <= fifo_data[7:0];
          tmr_q       <= PROG_CYCLES - 16'h0001;
        end else begin
          prog_run_q <= 1'b0;
        end
      end
    end
  end

endmodule // epwrs_slave

`default_nettype wire

// ### testbench/epwrs_bus_master.sv
// Two-wire bus master model that clocks the EEPROM slave
`default_nettype none

module epwrs_bus_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle with both lines high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Four cycles a phase, twice the slave's minimum
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data moves only while the clock is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_o <= b;
    wt(4);
    scl_o <= 1'b1;
    wt(4);
    s = sda_i;
    scl_o <= 1'b0;
    wt(2);
  endtask

  // Also serves as repeated start from a low clock
  task automatic start();
    sda_o <= 1'b1;
    wt(4);
    scl_o <= 1'b1;
    wt(4);
    sda_o <= 1'b0;
    wt(4);
    scl_o <= 1'b0;
    wt(4);
  endtask

  task automatic stop();
    sda_o <= 1'b0;
    wt(4);
    scl_o <= 1'b1;
    wt(4);
    sda_o <= 1'b1;
    wt(4);
  endtask

  // MSB first, then the ninth clock; mack high leaves the line released
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(mack, s);
    ack = ~s;
  endtask
endmodule // epwrs_bus_master

`default_nettype wire

// ### testbench/epwrs_slave_monitor.sv
// Port assertions for the two-wire EEPROM slave
`default_nettype none

module epwrs_slave_monitor #(
  parameter logic [15:0] PROG_CYCLES = 16'h0190
) (
  input wire logic       ref_clk_i,
  input wire logic       srst_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       prog_busy_o,
  input wire logic       wr_strobe_o,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o
);
  localparam int PCYC = int'(PROG_CYCLES);
  int         busy_n_q;
  int         strb_n_q;
  logic [7:0] addr_q;

  // Busy length and write count per program cycle, cleared when idle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !prog_busy_o) begin
      busy_n_q <= 0;
      strb_n_q <= 0;
    end else begin
      busy_n_q <= busy_n_q + 1;
      strb_n_q <= strb_n_q + int'(wr_strobe_o);
    end
    if (wr_strobe_o)
      addr_q <= wr_addr_o;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_launch;
    prog_busy_o ##1 wr_strobe_o;
  endsequence

  AST_OD_LOW: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  AST_OE_SCL_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("sda pulled while scl high");
  AST_NO_ACK_BUSY: assert property (prog_busy_o |-> !$rose(sda_oe_o))
    else $error("ack while programming");
  AST_LAUNCH: assert property ($rose(prog_busy_o) |-> s_launch)
    else $error("no write after program start");
  AST_STROBE_IN_BUSY: assert property (wr_strobe_o |-> prog_busy_o ##1 !wr_strobe_o)
    else $error("bad write strobe");
  AST_PROG_LEN: assert property ($fell(prog_busy_o) |->
    busy_n_q >= strb_n_q * PCYC - 1 && busy_n_q <= strb_n_q * PCYC + 3)
    else $error("program time wrong");
  AST_PAGE_NEXT: assert property (wr_strobe_o && strb_n_q == 1 |->
    wr_addr_o == addr_q + 8'h01)
    else $error("second byte address wrong");
  AST_ADDR_STABLE: assert property (!wr_strobe_o |-> $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write port moved");
endmodule // epwrs_slave_monitor

bind epwrs_slave epwrs_slave_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_epwrs_slave_monitor (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .prog_busy_o(prog_busy_o), .wr_strobe_o(wr_strobe_o),
  .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));

`default_nettype wire

// ### testbench/epwrs_slave_tb.sv
// Self-checking bench for the two-wire EEPROM slave
`include "epwrs_defs.vh"
`default_nettype none

module epwrs_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PCYC  = 16'h0190;
  localparam logic [2:0]  STRAP = 3'h5;
  logic        ref_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        scl, m_sda, sda_w, sda_o, sda_oe_o, busy, strb, ack;
  logic [7:0]  wa, wd, q, ptr;
  logic [7:0]  mem [256];
  logic [15:0] wq [$];
  int          n_errors    = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  always #10 ref_clk_i = ~ref_clk_i;
  // Open drain: a driven low wins over the released, pulled-up level
  assign sda_w = m_sda & ~(sda_oe_o & ~sda_o);

  epwrs_bus_master i_epwrs_bus_master (.clk_i(ref_clk_i), .sda_i(sda_w),
    .scl_o(scl), .sda_o(m_sda));
  epwrs_slave #(.PROG_CYCLES(PCYC)) i_epwrs_slave (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .clk_en_i(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .chip_strap_bit0(STRAP[0]), .chip_strap_bit1(STRAP[1]),
    .chip_strap_bit2(STRAP[2]), .prog_busy_o(busy), .wr_strobe_o(strb),
    .wr_addr_o(wa), .wr_data_o(wd));

  // Log array writes; a hang past the cycle ceiling ends the run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (strb === 1'b1)
      wq.push_back({wa, wd});
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e || $isunknown(g)) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] ctl(input logic [2:0] c, input logic rw);
    return {`EPWRS_DEV_CODE, c, rw};
  endfunction

  task automatic tx(input logic [7:0] d, input logic e, input string nm);
    i_epwrs_bus_master.xfer(d, 1'b1, q, ack);
    chk(nm, 16'(e), 16'(ack));
  endtask

  // Write n bytes at a; pb probes the slave while it programs
  task automatic t_write(input logic [7:0] a, input int n, input logic [23:0] d,
                         input logic pb);
    logic [7:0] x;
    i_epwrs_bus_master.start();
    tx(ctl(STRAP, 1'b0), 1'b1, "ctrl_ack");
    tx(a, 1'b1, "addr_ack");
    for (int i = 0; i < n; i++)
      tx(d[23-8*i -: 8], i < 2, "data_ack");
    i_epwrs_bus_master.stop();
    chk("busy", 16'(n < 3), 16'(busy));
    if (pb) begin
      i_epwrs_bus_master.start();
      tx(ctl(STRAP, 1'b0), 1'b0, "busy_ack");
      i_epwrs_bus_master.stop();
    end
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge ref_clk_i);
    chk("writes", 16'(n < 3 ? n : 0), 16'(wq.size()));
    for (int i = 0; i < wq.size(); i++) begin
      x = a + 8'(i);
      chk("wr", {x, d[23-8*i -: 8]}, wq[i]);
      mem[x] = d[23-8*i -: 8];
    end
    wq.delete();
  endtask

  // Optionally set the pointer, then read n bytes with a nack on the last
  task automatic t_read(input logic set, input logic [7:0] a, input int n);
    i_epwrs_bus_master.start();
    if (set) begin
      tx(ctl(STRAP, 1'b0), 1'b1, "ctrl_ack");
      tx(a, 1'b1, "addr_ack");
      ptr = a;
      i_epwrs_bus_master.start();
    end
    tx(ctl(STRAP, 1'b1), 1'b1, "rd_ack");
    for (int i = 1; i <= n; i++) begin
      i_epwrs_bus_master.xfer(8'hFF, i == n, q, ack);
      chk("rd_data", 16'(mem[ptr]), 16'(q));
      ptr++;
    end
    chk("released", 16'h0000, 16'(sda_oe_o));
    i_epwrs_bus_master.stop();
  endtask

  // Only the matching chip address and device code are answered
  task automatic t_select();
    for (int c = 0; c < 8; c++) begin
      i_epwrs_bus_master.start();
      tx(ctl(3'(c), 1'b0), 3'(c) == STRAP, "sel_ack");
      i_epwrs_bus_master.stop();
    end
    i_epwrs_bus_master.start();
    tx({~`EPWRS_DEV_CODE, STRAP, 1'b0}, 1'b0, "code_ack");
    i_epwrs_bus_master.stop();
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_write(8'h10, 1, 24'h5A0000, 1'b1);
    t_write(8'hFF, 2, 24'hA53C00, 1'b0);
    t_write(8'h01, 1, 24'h770000, 1'b0);
    t_write(8'h40, 3, 24'h112233, 1'b0);
    t_read(1'b1, 8'hFF, 3);
    t_read(1'b1, 8'hFF, 1);
    t_read(1'b0, 8'h00, 1);
    t_select();
    test_done();
  end
endmodule // epwrs_slave_tb

`default_nettype wire
